// >>> ectm_pkg.sv
package ectm_pkg;

  // Service kinds
  typedef enum logic [2:0] {
    SVC_CONTEXT,
    SVC_EVENT_COUNTER,
    SVC_BLOCK_MEM_TO_REG,
    SVC_BLOCK_REG_TO_MEM,
    SVC_PTR_BLOCK_MEM_TO_REG,
    SVC_PTR_BLOCK_REG_TO_MEM,
    SVC_DIFFERENCE,
    SVC_PTR_DIFFERENCE
  } ectm_svc_e;

  // Where a pointer-mode service keeps its data
  typedef enum logic [1:0] {
    AREA_INTERNAL_RAM,
    AREA_PERIPHERAL_RAM,
    AREA_EXTERNAL_MEMORY
  } ectm_area_e;

  // Short direct access pattern of one instruction
  typedef enum logic [2:0] {
    SD_NONE,
    SD_SINGLE_ONE,
    SD_SINGLE_TWO,
    SD_PAIR_MOVE,
    SD_PAIR_EXCHANGE,
    SD_PAIR_ALU
  } ectm_sd_e;

  // Special register operand targets
  typedef enum logic [1:0] {
    SR_NONE,
    SR_MEMORY_MODE,
    SR_WAIT_CONTROL
  } ectm_sr_e;

  // Service clock figures
  localparam logic [7:0] CTX_BASE        = 8'h11;
  localparam logic [7:0] EVT_CLOCKS      = 8'h0C;
  localparam logic [7:0] BLK_M2R_BYTE    = 8'h12;
  localparam logic [7:0] BLK_M2R_WORD    = 8'h13;
  localparam logic [7:0] BLK_R2M_BYTE    = 8'h11;
  localparam logic [7:0] BLK_R2M_WORD    = 8'h12;
  localparam logic [7:0] PTR_INTERNAL_RAM_AREA_BYTE   = 8'h14;
  localparam logic [7:0] PTR_INTERNAL_RAM_AREA_WORD   = 8'h15;
  localparam logic [7:0] PTR_PERIPHERAL_RAM_AREA_BYTE   = 8'h16;
  localparam logic [7:0] PTR_PERIPHERAL_RAM_AREA_EVEN   = 8'h17;
  localparam logic [7:0] PTR_PERIPHERAL_RAM_AREA_ODD    = 8'h1B;
  localparam logic [7:0] PTR_EXT_BYTE    = 8'h16;
  localparam logic [7:0] PTR_EXT_WORD    = 8'h1B;
  localparam logic [7:0] DIF_WORD        = 8'h16;
  localparam logic [7:0] PDIF_INTERNAL_RAM_AREA_WORD  = 8'h1A;
  localparam logic [7:0] PDIF_PERIPHERAL_RAM_AREA_EVEN  = 8'h1C;
  localparam logic [7:0] PDIF_PERIPHERAL_RAM_AREA_ODD   = 8'h20;
  localparam logic [7:0] PDIF_EXT_WORD   = 8'h20;

  // Instruction accounting figures
  localparam logic [7:0] FETCH_BASE      = 8'h03;
  localparam logic [7:0] SD_PENALTY      = 8'h04;
  localparam logic [7:0] BRANCH_BASE     = 8'h07;
  localparam logic [1:0] BRANCH_HS_SPAN  = 2'h1;
  localparam logic [1:0] BRANCH_NF_SPAN  = 2'h3;
  localparam logic [7:0] WAITCTRL_HS_ADD = 8'h01;

  // Address windows
  localparam logic [15:0] SD_AREA_LO     = 16'hFF00;
  localparam logic [15:0] SD_AREA_HI     = 16'hFF1F;
  localparam logic [15:0] MAIN_RAM_LO    = 16'hFE00;
  localparam logic [15:0] MAIN_RAM_HI    = 16'hFEFF;

endpackage : ectm_pkg

// >>> ectm_short_direct_counter.sv
`timescale 1ns/1ns
module ectm_short_direct_counter (
  // Instruction pattern and operand addresses
  input  wire ectm_pkg::ectm_sd_e sdClass,
  input  wire logic [15:0]        srcAddr,
  input  wire logic [15:0]        dstAddr,
  // Counted accesses into the register area
  output logic [2:0]              accessCount
);

  // Operand lies in the short direct register window
  wire srcIn = (srcAddr >= ectm_pkg::SD_AREA_LO) && (srcAddr <= ectm_pkg::SD_AREA_HI);
  wire dstIn = (dstAddr >= ectm_pkg::SD_AREA_LO) && (dstAddr <= ectm_pkg::SD_AREA_HI);
  wire anyIn = srcIn || dstIn;
  wire both  = srcIn && dstIn;

  // Pair counts: one or both operands in the window
  wire [2:0] pairMove = both ? 3'h2 : (anyIn ? 3'h1 : 3'h0);
  wire [2:0] pairXch  = both ? 3'h4 : (anyIn ? 3'h2 : 3'h0);
  // Source alone 1, destination alone 2, both 3
  wire [2:0] pairAlu  = {1'b0, dstIn, srcIn};

  // Single operand forms use the destination address
  assign accessCount =
    (sdClass == ectm_pkg::SD_SINGLE_ONE)    ? (dstIn ? 3'h1 : 3'h0) :
    (sdClass == ectm_pkg::SD_SINGLE_TWO)    ? (dstIn ? 3'h2 : 3'h0) :
    (sdClass == ectm_pkg::SD_PAIR_MOVE)     ? pairMove :
    (sdClass == ectm_pkg::SD_PAIR_EXCHANGE) ? pairXch :
    (sdClass == ectm_pkg::SD_PAIR_ALU)      ? pairAlu : 3'h0;

endmodule : ectm_short_direct_counter

// >>> ectm_timing_model.sv
`timescale 1ns/1ns
module ectm_timing_model #(
  parameter int CNT_W  = 16,
  parameter int WAIT_W = 2,
  parameter int INST_W = 8,
  parameter int BYTE_W = 4
) (
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rstn,
  // Fetch configuration
  input  wire logic                        highSpeedSel,
  input  wire logic                        codeInternal,
  input  wire logic [WAIT_W-1:0]           waitCount,
  // Instruction record
  input  wire logic                        seqStart,
  input  wire logic                        seqEnd,
  input  wire logic                        instValid,
  input  wire logic [INST_W-1:0]           instClocks,
  input  wire logic [BYTE_W-1:0]           instBytes,
  input  wire ectm_pkg::ectm_sd_e          sdClass,
  input  wire logic [15:0]                 srcAddr,
  input  wire logic [15:0]                 dstAddr,
  input  wire ectm_pkg::ectm_sr_e          specialReg,
  input  wire logic [1:0]                  specialCount,
  input  wire logic                        branchTaken,
  input  wire logic [1:0]                  queuePhase,
  input  wire logic                        wordAccess,
  input  wire logic [15:0]                 dataAddr,
  // Service request
  input  wire logic                        svcReq,
  input  wire ectm_pkg::ectm_svc_e         svcKind,
  input  wire ectm_pkg::ectm_area_e        svcArea,
  input  wire logic                        svcWord,
  input  wire logic                        svcOdd,
  // Results
  output logic [CNT_W-1:0]                 seqBasic,
  output logic [CNT_W-1:0]                 seqTotal,
  output logic                             seqDone,
  output logic [CNT_W-1:0]                 svcClocks,
  output logic                             svcDone,
  output logic                             oddWordFault
);

  // Accumulators and result flops
  logic [CNT_W-1:0] sumClk_reg;
  logic [CNT_W-1:0] sumBytes_reg;
  logic [CNT_W-1:0] corr_reg;
  logic [CNT_W-1:0] seqBasic_reg;
  logic [CNT_W-1:0] seqTotal_reg;
  logic             seqDone_reg;
  logic [CNT_W-1:0] svcClocks_reg;
  logic             svcDone_reg;
  logic             oddFault_reg;
  logic [2:0]       sdCount;

  // Wait count and its double at counter width
  wire [CNT_W-1:0] nW  = CNT_W'(waitCount);
  wire [CNT_W-1:0] n2W = CNT_W'({waitCount, 1'b0});

  // High-speed only counts for internal code with the mode selected
  wire hsEff = highSpeedSel && codeInternal;

  // Service cost selection
  wire [CNT_W-1:0] ctxCost  = CNT_W'(ectm_pkg::CTX_BASE) + n2W;
  wire [CNT_W-1:0] blkM2R   = CNT_W'(svcWord ? ectm_pkg::BLK_M2R_WORD
                                             : ectm_pkg::BLK_M2R_BYTE);
  wire [CNT_W-1:0] blkR2M   = CNT_W'(svcWord ? ectm_pkg::BLK_R2M_WORD
                                             : ectm_pkg::BLK_R2M_BYTE);
  wire [CNT_W-1:0] pramWord = CNT_W'(svcOdd ? ectm_pkg::PTR_PERIPHERAL_RAM_AREA_ODD
                                            : ectm_pkg::PTR_PERIPHERAL_RAM_AREA_EVEN);
  wire [CNT_W-1:0] ptrIram  = CNT_W'(svcWord ? ectm_pkg::PTR_INTERNAL_RAM_AREA_WORD
                                             : ectm_pkg::PTR_INTERNAL_RAM_AREA_BYTE);
  wire [CNT_W-1:0] ptrPram  = svcWord ? pramWord : CNT_W'(ectm_pkg::PTR_PERIPHERAL_RAM_AREA_BYTE);
  wire [CNT_W-1:0] ptrExt   = svcWord ? CNT_W'(ectm_pkg::PTR_EXT_WORD) + n2W
                                      : CNT_W'(ectm_pkg::PTR_EXT_BYTE) + nW;
  wire [CNT_W-1:0] ptrCost  =
    (svcArea == ectm_pkg::AREA_INTERNAL_RAM)   ? ptrIram :
    (svcArea == ectm_pkg::AREA_PERIPHERAL_RAM) ? ptrPram : ptrExt;
  // Difference services exist in word form only; byte requests cost the same
  wire [CNT_W-1:0] pdifCost =
    (svcArea == ectm_pkg::AREA_INTERNAL_RAM)   ? CNT_W'(ectm_pkg::PDIF_INTERNAL_RAM_AREA_WORD) :
    (svcArea == ectm_pkg::AREA_PERIPHERAL_RAM) ?
      CNT_W'(svcOdd ? ectm_pkg::PDIF_PERIPHERAL_RAM_AREA_ODD : ectm_pkg::PDIF_PERIPHERAL_RAM_AREA_EVEN) :
      CNT_W'(ectm_pkg::PDIF_EXT_WORD) + n2W;
  wire [CNT_W-1:0] svcCost  =
    (svcKind == ectm_pkg::SVC_CONTEXT)              ? ctxCost :
    (svcKind == ectm_pkg::SVC_EVENT_COUNTER)        ? CNT_W'(ectm_pkg::EVT_CLOCKS) :
    (svcKind == ectm_pkg::SVC_BLOCK_MEM_TO_REG)     ? blkM2R :
    (svcKind == ectm_pkg::SVC_BLOCK_REG_TO_MEM)     ? blkR2M :
    (svcKind == ectm_pkg::SVC_DIFFERENCE)           ? CNT_W'(ectm_pkg::DIF_WORD) :
    (svcKind == ectm_pkg::SVC_PTR_DIFFERENCE)       ? pdifCost : ptrCost;

  // Short direct access count of the current instruction
  ectm_short_direct_counter u_sd (
    .sdClass     (sdClass),
    .srcAddr     (srcAddr),
    .dstAddr     (dstAddr),
    .accessCount (sdCount)
  );

  // Four clocks per counted register-window access
  wire [CNT_W-1:0] sdCorr = CNT_W'(sdCount) * CNT_W'(ectm_pkg::SD_PENALTY);

  // Special register surcharge per access depends on fetch mode
  wire [CNT_W-1:0] srPer =
    (specialReg == ectm_pkg::SR_MEMORY_MODE)  ? (hsEff ? '0 : nW) :
    (specialReg == ectm_pkg::SR_WAIT_CONTROL) ?
      (hsEff ? CNT_W'(ectm_pkg::WAITCTRL_HS_ADD) : '0) : '0;
  wire [CNT_W-1:0] srCorr = srPer * CNT_W'(specialCount);

  // Queue refill: fetch phase picks a point inside the documented range
  wire [1:0]       brSpan  = hsEff ? ectm_pkg::BRANCH_HS_SPAN : ectm_pkg::BRANCH_NF_SPAN;
  wire [1:0]       brPhase = (queuePhase > brSpan) ? brSpan : queuePhase;
  wire [CNT_W-1:0] brCorr  = CNT_W'(ectm_pkg::BRANCH_BASE) + CNT_W'(brPhase)
                             + (hsEff ? '0 : nW);

  // Correction contributed by this instruction
  wire [CNT_W-1:0] instCorr = sdCorr + srCorr + (branchTaken ? brCorr : '0);

  // Accumulator next values; a start in the same cycle drops old totals
  wire [CNT_W-1:0] clkBase   = seqStart ? '0 : sumClk_reg;
  wire [CNT_W-1:0] byteBase  = seqStart ? '0 : sumBytes_reg;
  wire [CNT_W-1:0] corrBase  = seqStart ? '0 : corr_reg;
  wire [CNT_W-1:0] sumClk_next   = clkBase + (instValid ? CNT_W'(instClocks) : '0);
  wire [CNT_W-1:0] sumBytes_next = byteBase + (instValid ? CNT_W'(instBytes) : '0);
  wire [CNT_W-1:0] corr_next     = corrBase + (instValid ? instCorr : '0);

  // Basic count: plain sum or fetch-limited maximum
  wire [CNT_W-1:0] fetchCost  = sumBytes_next * (CNT_W'(ectm_pkg::FETCH_BASE) + nW);
  wire [CNT_W-1:0] nfBasic    = (fetchCost > sumClk_next) ? fetchCost : sumClk_next;
  wire [CNT_W-1:0] basic_next = hsEff ? sumClk_next : nfBasic;
  wire [CNT_W-1:0] total_next = basic_next + corr_next;

  // Odd word address into main RAM is a software fault, flagged not fixed
  wire inMainRam = (dataAddr >= ectm_pkg::MAIN_RAM_LO) && (dataAddr <= ectm_pkg::MAIN_RAM_HI);
  wire oddHit    = instValid && wordAccess && inMainRam && dataAddr[0];

  // Sequence accumulators
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sumClk_reg   <= '0;
      sumBytes_reg <= '0;
      corr_reg     <= '0;
    end else begin
      sumClk_reg   <= sumClk_next;
      sumBytes_reg <= sumBytes_next;
      corr_reg     <= corr_next;
    end
  end

  // Sequence result, held until the next sequence end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      seqBasic_reg <= '0;
      seqTotal_reg <= '0;
      seqDone_reg  <= 1'b0;
    end else begin
      seqDone_reg <= seqEnd;
      if (seqEnd) begin
        seqBasic_reg <= basic_next;
        seqTotal_reg <= total_next;
      end
    end
  end

  // Service result and fault pulse
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      svcClocks_reg <= '0;
      svcDone_reg   <= 1'b0;
      oddFault_reg  <= 1'b0;
    end else begin
      svcDone_reg  <= svcReq;
      oddFault_reg <= oddHit;
      if (svcReq) begin
        svcClocks_reg <= svcCost;
      end
    end
  end

  // Outputs straight from flops
  assign seqBasic     = seqBasic_reg;
  assign seqTotal     = seqTotal_reg;
  assign seqDone      = seqDone_reg;
  assign svcClocks    = svcClocks_reg;
  assign svcDone      = svcDone_reg;
  assign oddWordFault = oddFault_reg;

  // Service request shapes
  sequence s_ctxReq;
    svcReq && (svcKind == ectm_pkg::SVC_CONTEXT);
  endsequence
  sequence s_evtReq;
    svcReq && (svcKind == ectm_pkg::SVC_EVENT_COUNTER);
  endsequence
  sequence s_pramWordReq;
    svcReq && svcWord && (svcArea == ectm_pkg::AREA_PERIPHERAL_RAM)
      && (svcKind == ectm_pkg::SVC_PTR_BLOCK_MEM_TO_REG);
  endsequence

  property p_context;
    @(posedge mclk) disable iff (!rstn)
      s_ctxReq |=> svcDone && (svcClocks == 17 + 2 * $past(waitCount));
  endproperty
  a_context: assert property (p_context) else $error("context switch cost wrong");

  property p_event;
    @(posedge mclk) disable iff (!rstn)
      s_evtReq |=> svcDone && (svcClocks == 12);
  endproperty
  a_event: assert property (p_event) else $error("event counter cost wrong");

  property p_block_word;
    @(posedge mclk) disable iff (!rstn)
      (svcReq && svcWord && svcKind == ectm_pkg::SVC_BLOCK_REG_TO_MEM) |=> (svcClocks == 18);
  endproperty
  a_block_word: assert property (p_block_word) else $error("block word cost wrong");

  property p_peripheral_ram_area_parity;
    @(posedge mclk) disable iff (!rstn)
      s_pramWordReq |=> (svcClocks == ($past(svcOdd) ? 27 : 23));
  endproperty
  a_peripheral_ram_area_parity: assert property (p_peripheral_ram_area_parity) else $error("pointer parity cost");

  property p_hs_basic;
    @(posedge mclk) disable iff (!rstn)
      (seqEnd && hsEff) |=> (seqBasic == $past(sumClk_next));
  endproperty
  a_hs_basic: assert property (p_hs_basic) else $error("high-speed basic wrong");

  property p_nf_floor;
    @(posedge mclk) disable iff (!rstn)
      (seqEnd && !hsEff) |=>
        (seqBasic >= $past(sumClk_next)) &&
        (seqBasic >= $past(sumBytes_next) * (3 + $past(waitCount)));
  endproperty
  a_nf_floor: assert property (p_nf_floor) else $error("normal fetch basic low");

  property p_internal_normal;
    @(posedge mclk) disable iff (!rstn)
      (seqEnd && codeInternal && !highSpeedSel) |=>
        (seqBasic >= $past(sumBytes_next) * (3 + $past(waitCount)));
  endproperty
  a_internal_normal: assert property (p_internal_normal) else $error("mode ignored");

  property p_single_access;
    @(posedge mclk) disable iff (!rstn)
      (instValid && !branchTaken && specialReg == ectm_pkg::SR_NONE
        && sdClass == ectm_pkg::SD_SINGLE_TWO && dstAddr == ectm_pkg::SD_AREA_HI)
        |=> (corr_reg == $past(corrBase) + 8);
  endproperty
  a_single_access: assert property (p_single_access) else $error("short direct add");

  property p_alu_both;
    @(posedge mclk) disable iff (!rstn)
      (sdClass == ectm_pkg::SD_PAIR_ALU && srcAddr >= ectm_pkg::SD_AREA_LO
        && srcAddr <= ectm_pkg::SD_AREA_HI && dstAddr >= ectm_pkg::SD_AREA_LO
        && dstAddr <= ectm_pkg::SD_AREA_HI) |-> (sdCount == 3);
  endproperty
  a_alu_both: assert property (p_alu_both) else $error("alu access count wrong");

  property p_waitctrl_hs;
    @(posedge mclk) disable iff (!rstn)
      (instValid && hsEff && !branchTaken && sdClass == ectm_pkg::SD_NONE
        && specialReg == ectm_pkg::SR_WAIT_CONTROL)
        |=> (corr_reg == $past(corrBase) + $past(specialCount));
  endproperty
  a_waitctrl_hs: assert property (p_waitctrl_hs) else $error("wait register add");

  property p_branch_hs;
    @(posedge mclk) disable iff (!rstn)
      (instValid && hsEff && branchTaken && sdClass == ectm_pkg::SD_NONE
        && specialReg == ectm_pkg::SR_NONE)
        |=> (corr_reg >= $past(corrBase) + 7) && (corr_reg <= $past(corrBase) + 8);
  endproperty
  a_branch_hs: assert property (p_branch_hs) else $error("branch refill out of range");

  property p_odd_fault;
    @(posedge mclk) disable iff (!rstn)
      (instValid && wordAccess && dataAddr == 16'hFE01) |=> oddWordFault;
  endproperty
  a_odd_fault: assert property (p_odd_fault) else $error("odd word not flagged");

  property p_total;
    @(posedge mclk) disable iff (!rstn)
      seqEnd |=> (seqTotal == seqBasic + $past(corr_next));
  endproperty
  a_total: assert property (p_total) else $error("total mismatch");

endmodule : ectm_timing_model

// >>> tb.sv
`timescale 1ns/1ns
module tb;
  // One single-instruction sequence: mode {hs,internal,n}, inputs, expected counts
  typedef struct packed {
    logic [3:0]  cfg;
    logic [7:0]  clk;
    logic [3:0]  byt;
    logic [2:0]  sd;
    logic [15:0] src;
    logic [15:0] dst;
    logic [1:0]  sr;
    logic [1:0]  sc;
    logic        br;
    logic [1:0]  ph;
    logic [7:0]  basic;
    logic [7:0]  total;
  } ectm_row_s;
  // One service request: kind, area, word, odd, n, expected clocks
  typedef struct packed {
    logic [2:0] k;
    logic [1:0] a;
    logic       w;
    logic       o;
    logic [1:0] n;
    logic [7:0] e;
  } ectm_svc_s;

  // Design inputs, all defined at time zero
  logic                      mclk = 1'b0;
  logic                      rstn = 1'b0;
  logic                      highSpeedSel = 1'b0;
  logic                      codeInternal = 1'b0;
  logic [1:0]                waitCount = 2'h0;
  logic                      seqStart = 1'b0;
  logic                      seqEnd = 1'b0;
  logic                      instValid = 1'b0;
  logic [7:0]                instClocks = 8'h00;
  logic [3:0]                instBytes = 4'h0;
  ectm_pkg::ectm_sd_e        sdClass = ectm_pkg::SD_NONE;
  logic [15:0]               srcAddr = 16'h0000;
  logic [15:0]               dstAddr = 16'h0000;
  ectm_pkg::ectm_sr_e        specialReg = ectm_pkg::SR_NONE;
  logic [1:0]                specialCount = 2'h0;
  logic                      branchTaken = 1'b0;
  logic [1:0]                queuePhase = 2'h0;
  logic                      wordAccess = 1'b0;
  logic [15:0]               dataAddr = 16'h0000;
  logic                      svcReq = 1'b0;
  ectm_pkg::ectm_svc_e       svcKind = ectm_pkg::SVC_CONTEXT;
  ectm_pkg::ectm_area_e      svcArea = ectm_pkg::AREA_INTERNAL_RAM;
  logic                      svcWord = 1'b0;
  logic                      svcOdd = 1'b0;
  // Design outputs and bookkeeping
  logic [15:0]               seqBasic;
  logic [15:0]               seqTotal;
  logic                      seqDone;
  logic [15:0]               svcClocks;
  logic                      svcDone;
  logic                      oddWordFault;
  int                        bad_count = 0;
  int                        check_count = 0;

  ectm_timing_model u_ectm_timing_model (
    .mclk(mclk), .rstn(rstn), .highSpeedSel(highSpeedSel), .codeInternal(codeInternal),
    .waitCount(waitCount), .seqStart(seqStart), .seqEnd(seqEnd), .instValid(instValid),
    .instClocks(instClocks), .instBytes(instBytes), .sdClass(sdClass), .srcAddr(srcAddr),
    .dstAddr(dstAddr), .specialReg(specialReg), .specialCount(specialCount),
    .branchTaken(branchTaken), .queuePhase(queuePhase), .wordAccess(wordAccess),
    .dataAddr(dataAddr), .svcReq(svcReq), .svcKind(svcKind), .svcArea(svcArea),
    .svcWord(svcWord), .svcOdd(svcOdd), .seqBasic(seqBasic), .seqTotal(seqTotal),
    .seqDone(seqDone), .svcClocks(svcClocks), .svcDone(svcDone), .oddWordFault(oddWordFault)
  );

  // Sequence table; short direct rows run in high-speed mode so the basic stays at clocks
  ectm_row_s rows [0:22] = '{
    '{4'hC,8'h06,4'h4,3'h0,16'h0000,16'h0000,2'h0,2'h0,1'b0,2'h0,8'h06,8'h06},
    '{4'h7,8'h06,4'h4,3'h0,16'h0000,16'h0000,2'h0,2'h0,1'b0,2'h0,8'h18,8'h18},
    '{4'h9,8'h06,4'h4,3'h0,16'h0000,16'h0000,2'h0,2'h0,1'b0,2'h0,8'h10,8'h10},
    '{4'h0,8'h0E,4'h4,3'h0,16'h0000,16'h0000,2'h0,2'h0,1'b0,2'h0,8'h0E,8'h0E},
    '{4'hC,8'h0A,4'h1,3'h1,16'h0000,16'hFF00,2'h0,2'h0,1'b0,2'h0,8'h0A,8'h0E},
    '{4'hC,8'h0A,4'h1,3'h1,16'h0000,16'hFF20,2'h0,2'h0,1'b0,2'h0,8'h0A,8'h0A},
    '{4'hC,8'h0A,4'h1,3'h2,16'h0000,16'hFF1F,2'h0,2'h0,1'b0,2'h0,8'h0A,8'h12},
    '{4'hC,8'h0A,4'h1,3'h0,16'h0000,16'hFF10,2'h0,2'h0,1'b0,2'h0,8'h0A,8'h0A},
    '{4'hC,8'h0A,4'h1,3'h3,16'hFF05,16'hFE00,2'h0,2'h0,1'b0,2'h0,8'h0A,8'h0E},
    '{4'hC,8'h0A,4'h1,3'h3,16'hFF01,16'hFF1F,2'h0,2'h0,1'b0,2'h0,8'h0A,8'h12},
    '{4'hC,8'h0A,4'h1,3'h4,16'hFE00,16'hFF03,2'h0,2'h0,1'b0,2'h0,8'h0A,8'h12},
    '{4'hC,8'h0A,4'h1,3'h4,16'hFF00,16'hFF1E,2'h0,2'h0,1'b0,2'h0,8'h0A,8'h1A},
    '{4'hC,8'h0A,4'h1,3'h5,16'hFF00,16'hFE10,2'h0,2'h0,1'b0,2'h0,8'h0A,8'h0E},
    '{4'hC,8'h0A,4'h1,3'h5,16'hFE10,16'hFF00,2'h0,2'h0,1'b0,2'h0,8'h0A,8'h12},
    '{4'hC,8'h0A,4'h1,3'h5,16'hFF08,16'hFF09,2'h0,2'h0,1'b0,2'h0,8'h0A,8'h16},
    '{4'h7,8'h0A,4'h1,3'h0,16'h0000,16'h0000,2'h1,2'h2,1'b0,2'h0,8'h0A,8'h10},
    '{4'hC,8'h0A,4'h1,3'h0,16'h0000,16'h0000,2'h1,2'h2,1'b0,2'h0,8'h0A,8'h0A},
    '{4'hC,8'h0A,4'h1,3'h0,16'h0000,16'h0000,2'h2,2'h2,1'b0,2'h0,8'h0A,8'h0C},
    '{4'h7,8'h0A,4'h1,3'h0,16'h0000,16'h0000,2'h2,2'h2,1'b0,2'h0,8'h0A,8'h0A},
    '{4'hC,8'h0A,4'h1,3'h0,16'h0000,16'h0000,2'h0,2'h0,1'b1,2'h0,8'h0A,8'h11},
    '{4'hC,8'h0A,4'h1,3'h0,16'h0000,16'h0000,2'h0,2'h0,1'b1,2'h3,8'h0A,8'h12},
    '{4'h6,8'h0A,4'h1,3'h0,16'h0000,16'h0000,2'h0,2'h0,1'b1,2'h3,8'h0A,8'h16},
    '{4'h5,8'h0A,4'h1,3'h0,16'h0000,16'h0000,2'h0,2'h0,1'b1,2'h0,8'h0A,8'h12}};
  // Service table, kinds and areas in package declaration order
  ectm_svc_s svcs [0:22] = '{
    '{3'h0,2'h0,1'b0,1'b0,2'h1,8'h13}, '{3'h0,2'h0,1'b0,1'b0,2'h3,8'h17},
    '{3'h1,2'h0,1'b0,1'b0,2'h0,8'h0C}, '{3'h2,2'h0,1'b0,1'b0,2'h0,8'h12},
    '{3'h2,2'h0,1'b1,1'b0,2'h0,8'h13}, '{3'h3,2'h0,1'b0,1'b0,2'h0,8'h11},
    '{3'h3,2'h0,1'b1,1'b0,2'h0,8'h12}, '{3'h4,2'h0,1'b0,1'b0,2'h0,8'h14},
    '{3'h4,2'h0,1'b1,1'b0,2'h0,8'h15}, '{3'h4,2'h1,1'b0,1'b0,2'h0,8'h16},
    '{3'h4,2'h1,1'b1,1'b0,2'h0,8'h17}, '{3'h4,2'h1,1'b1,1'b1,2'h0,8'h1B},
    '{3'h4,2'h2,1'b0,1'b0,2'h2,8'h18}, '{3'h4,2'h2,1'b1,1'b0,2'h2,8'h1F},
    '{3'h5,2'h1,1'b1,1'b1,2'h0,8'h1B}, '{3'h5,2'h2,1'b1,1'b0,2'h3,8'h21},
    '{3'h5,2'h2,1'b0,1'b0,2'h1,8'h17}, '{3'h6,2'h0,1'b1,1'b0,2'h0,8'h16},
    '{3'h6,2'h0,1'b0,1'b0,2'h0,8'h16}, '{3'h7,2'h0,1'b1,1'b0,2'h0,8'h1A},
    '{3'h7,2'h1,1'b1,1'b0,2'h0,8'h1C}, '{3'h7,2'h1,1'b1,1'b1,2'h0,8'h20},
    '{3'h7,2'h2,1'b1,1'b0,2'h1,8'h22}};
  logic [3:0] cfgs [0:2] = '{4'h0, 4'h3, 4'hC};
  logic [7:0] tots [0:2] = '{8'h16, 8'h20, 8'h16};

  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk16

  task automatic chk1(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  // One instruction record; mode is held until the close so seqEnd sees it
  task automatic inst(input ectm_row_s r, input logic st, input logic en);
    @(posedge mclk);
    highSpeedSel <= r.cfg[3];
    codeInternal <= r.cfg[2];
    waitCount    <= r.cfg[1:0];
    seqStart     <= st;
    seqEnd       <= en;
    instValid    <= 1'b1;
    instClocks   <= r.clk;
    instBytes    <= r.byt;
    sdClass      <= ectm_pkg::ectm_sd_e'(r.sd);
    srcAddr      <= r.src;
    dstAddr      <= r.dst;
    specialReg   <= ectm_pkg::ectm_sr_e'(r.sr);
    specialCount <= r.sc;
    branchTaken  <= r.br;
    queuePhase   <= r.ph;
    #1;
    chk1("seqDone idle", 1'b0, seqDone);
  endtask : inst

  // Done pulse lands one edge after seqEnd
  task automatic close_seq(input logic [7:0] b, input logic [7:0] t);
    @(posedge mclk);
    instValid <= 1'b0;
    seqStart  <= 1'b0;
    seqEnd    <= 1'b0;
    #1;
    chk1("seqDone", 1'b1, seqDone);
    chk16("seqBasic", {8'h00, b}, seqBasic);
    chk16("seqTotal", {8'h00, t}, seqTotal);
  endtask : close_seq

  task automatic svc(input ectm_svc_s r);
    @(posedge mclk);
    svcReq    <= 1'b1;
    svcKind   <= ectm_pkg::ectm_svc_e'(r.k);
    svcArea   <= ectm_pkg::ectm_area_e'(r.a);
    svcWord   <= r.w;
    svcOdd    <= r.o;
    waitCount <= r.n;
    @(posedge mclk);
    svcReq <= 1'b0;
    #1;
    chk1("svcDone", 1'b1, svcDone);
    chk16("svcClocks", {8'h00, r.e}, svcClocks);
  endtask : svc

  // Free-running clock
  initial begin
    forever #2 mclk = ~mclk;
  end

  // Guard against a hang anywhere in the sequence
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    $display("mismatch watchdog expected finish seen timeout");
    results();
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge mclk);
    #1;
    chk16("seqTotal in reset", 16'h0000, seqTotal);
    chk1("svcDone in reset", 1'b0, svcDone);
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    #1;
    chk16("svcClocks after reset", 16'h0000, svcClocks);
    $display("test reset done");
    foreach (rows[i]) begin
      inst(rows[i], 1'b1, 1'b1);
      close_seq(rows[i].basic, rows[i].total);
    end
    $display("test sequence table done");
    foreach (svcs[i]) begin
      svc(svcs[i]);
    end
    $display("test service table done");
    // Three-instruction example: sums, byte rate, corrections accumulate
    for (int m = 0; m < 3; m++) begin
      inst('{cfgs[m],8'h06,4'h1,3'h0,16'h0,16'h0,2'h0,2'h0,1'b0,2'h0,8'h0,8'h0}, 1'b1, 1'b0);
      inst('{cfgs[m],8'h03,4'h2,3'h5,16'hFE20,16'hFF00,2'h0,2'h0,1'b0,2'h0,8'h0,8'h0}, 1'b0, 1'b0);
      inst('{cfgs[m],8'h05,4'h1,3'h0,16'h0,16'h0,2'h0,2'h0,1'b0,2'h0,8'h0,8'h0}, 1'b0, 1'b1);
      close_seq((m == 1) ? 8'h18 : 8'h0E, tots[m]);
    end
    $display("test multi instruction done");
    // Back-to-back services with no idle cycle between them
    @(posedge mclk);
    svcReq    <= 1'b1;
    svcKind   <= ectm_pkg::SVC_CONTEXT;
    waitCount <= 2'h0;
    @(posedge mclk);
    svcKind <= ectm_pkg::SVC_EVENT_COUNTER;
    #1;
    chk16("svcClocks ctx", 16'h0011, svcClocks);
    @(posedge mclk);
    svcReq <= 1'b0;
    #1;
    chk16("svcClocks evt", 16'h000C, svcClocks);
    @(posedge mclk);
    #1;
    chk1("svcDone drop", 1'b0, svcDone);
    chk16("svcClocks held", 16'h000C, svcClocks);
    $display("test back to back done");
    // Odd word access in main RAM is flagged; even or outside addresses are not
    @(posedge mclk);
    instValid  <= 1'b1;
    seqStart   <= 1'b1;
    wordAccess <= 1'b1;
    dataAddr   <= 16'hFE01;
    @(posedge mclk);
    seqStart <= 1'b0;
    dataAddr <= 16'hFE02;
    #1;
    chk1("oddWordFault odd", 1'b1, oddWordFault);
    @(posedge mclk);
    dataAddr <= 16'hFF01;
    #1;
    chk1("oddWordFault even", 1'b0, oddWordFault);
    @(posedge mclk);
    dataAddr <= 16'hFEFF;
    #1;
    chk1("oddWordFault outside", 1'b0, oddWordFault);
    @(posedge mclk);
    instValid  <= 1'b0;
    wordAccess <= 1'b0;
    #1;
    chk1("oddWordFault top", 1'b1, oddWordFault);
    $display("test odd word done");
    // Mid-run reset clears held results at once
    @(posedge mclk);
    rstn <= 1'b0;
    #1;
    chk16("seqTotal reset", 16'h0000, seqTotal);
    chk16("svcClocks reset", 16'h0000, svcClocks);
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    inst(rows[4], 1'b1, 1'b1);
    close_seq(8'h0A, 8'h0E);
    $display("test mid reset done");
    results();
  end
endmodule : tb
